/* bmd_decoder.sv */
// Purpose: Boot memory selection and first-level address decode toward memory slaves
// Assumes: One request at a time, answered one cycle after it is taken
// Notes: Requests are refused (ready low) until the boot strap has been captured
`timescale 1ns/1ps
module bmd_decoder #(
    parameter int NUM_CS_P = bmd_pkg::NUM_CS,
    parameter int EXT_ADDR_W_P = bmd_pkg::EXT_ADDR_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic boot_select_pin_i,
    input wire logic osc_xtal_sel_i,
    input wire logic remap_i,
    input wire logic cs1_sdram_i,
    input wire logic cs3_nand_i,
    input wire logic cs45_card_i,
    input wire logic clk_switch_done_i,
    input wire logic smem_cfg_load_i,
    input wire logic smem_cfg_byte_sel_i,
    input wire logic [1:0] smem_cfg_width_i,
    input wire logic smem_cfg_rw_by_cs_i,
    input wire logic req_valid_i,
    input wire logic [bmd_pkg::ADDR_W-1:0] req_addr_i,
    input wire logic [bmd_pkg::EXT_DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic resp_valid_o,
    output logic resp_abort_o,
    output bmd_pkg::bmd_tgt_e resp_tgt_o,
    output logic [bmd_pkg::ADDR_W-1:0] resp_offset_o,
    output logic [NUM_CS_P-1:0] ext_chip_select_n_o,
    output logic [EXT_ADDR_W_P-1:0] ext_addr_o,
    output logic [bmd_pkg::EXT_DATA_W-1:0] ext_wdata_o,
    output logic ext_cs_to_sdram_o,
    output logic ext_nand_logic_o,
    output logic ext_card_logic_o,
    output logic boot_rom_o,
    output logic slow_clk_boot_o,
    output logic slow_src_xtal_o,
    output logic smem_cs0_byte_sel_o,
    output logic [1:0] smem_cs0_width_o,
    output logic smem_cs0_rw_by_cs_o
);
    import bmd_pkg::*;

    // Select decode is one-hot over exactly eight lines; pins cannot exceed a bank
    if (NUM_CS_P != 8 || EXT_ADDR_W_P < 1 || EXT_ADDR_W_P > 28) begin : g_bad_params
        $error("bmd_decoder: unsupported chip select count or address width");
    end

    function automatic logic [3:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[BANK_MSB:BANK_LSB];
    endfunction : bank_of

    logic boot_rom_w;
    logic slow_xtal_w;
    logic captured_w;

    bmd_strap_latch u_strap (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .boot_select_pin_i(boot_select_pin_i),
        .osc_xtal_sel_i(osc_xtal_sel_i),
        .boot_rom_o(boot_rom_w),
        .slow_src_xtal_o(slow_xtal_w),
        .captured_o(captured_w)
    );

    // Decode group
    logic taken;
    logic req_ready_nxt;
    logic resp_valid_nxt;
    logic resp_abort_nxt;
    bmd_tgt_e resp_tgt_nxt;
    logic [ADDR_W-1:0] resp_offset_nxt;
    logic [NUM_CS_P-1:0] cs_n_nxt;
    logic [EXT_ADDR_W_P-1:0] ext_addr_nxt;
    logic [EXT_DATA_W-1:0] ext_wdata_nxt;
    logic [3:0] bank;
    logic [3:0] cs_idx;

    assign taken = req_valid_i && req_ready_o;

    always_comb begin
        bank = bank_of(req_addr_i);
        cs_idx = 4'h0;
        req_ready_nxt = captured_w;
        resp_valid_nxt = taken;
        resp_abort_nxt = 1'b0;
        resp_tgt_nxt = TGT_NONE;
        resp_offset_nxt = '0;
        cs_n_nxt = '1;
        ext_addr_nxt = ext_addr_o;
        ext_wdata_nxt = ext_wdata_o;
        if (taken) begin
            resp_offset_nxt = {4'h0, req_addr_i[BANK_LSB-1:0]};
            if (bank == BANK_INT) begin
                if (req_addr_i <= BOOT_AREA_LAST) begin
                    if (remap_i) begin
                        resp_tgt_nxt = TGT_SRAM0;
                    end else if (boot_rom_w == BOOT_SEL_ROM) begin
                        resp_tgt_nxt = TGT_ROM;
                    end else begin
                        resp_tgt_nxt = TGT_EXT;
                        cs_n_nxt[0] = 1'b0;
                        ext_addr_nxt = req_addr_i[EXT_ADDR_W_P-1:0];
                        ext_wdata_nxt = req_wdata_i;
                    end
                end else begin
                    resp_tgt_nxt = TGT_INTMEM;
                end
            end else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST) begin
                // One 256-Mbyte bank per select; only the low 26 bits reach the pins
                cs_idx = bank - BANK_EXT_FIRST;
                resp_tgt_nxt = TGT_EXT;
                cs_n_nxt[cs_idx[2:0]] = 1'b0;
                ext_addr_nxt = req_addr_i[EXT_ADDR_W_P-1:0];
                ext_wdata_nxt = req_wdata_i;
            end else if (bank == BANK_PERIPH) begin
                resp_tgt_nxt = TGT_PERIPH;
            end else begin
                resp_abort_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_ready_o <= 1'b0;
            resp_valid_o <= 1'b0;
            resp_abort_o <= 1'b0;
            resp_tgt_o <= TGT_NONE;
            resp_offset_o <= '0;
            ext_chip_select_n_o <= '1;
            ext_addr_o <= '0;
            ext_wdata_o <= '0;
        end else begin
            req_ready_o <= req_ready_nxt;
            resp_valid_o <= resp_valid_nxt;
            resp_abort_o <= resp_abort_nxt;
            resp_tgt_o <= resp_tgt_nxt;
            resp_offset_o <= resp_offset_nxt;
            ext_chip_select_n_o <= cs_n_nxt;
            ext_addr_o <= ext_addr_nxt;
            ext_wdata_o <= ext_wdata_nxt;
        end
    end

    // Configuration group: chip select assignment, boot clock, static memory defaults
    logic cs_sdram_nxt;
    logic nand_nxt;
    logic card_nxt;
    logic slow_boot_nxt;
    logic byte_sel_nxt;
    logic [1:0] width_nxt;
    logic rw_by_cs_nxt;

    always_comb begin
        // Selects 0, 2, 6 and 7 have no alternative owner, so no control exists for them
        cs_sdram_nxt = cs1_sdram_i;
        nand_nxt = cs3_nand_i;
        card_nxt = cs45_card_i;
        slow_boot_nxt = slow_clk_boot_o && !clk_switch_done_i;
        byte_sel_nxt = smem_cs0_byte_sel_o;
        width_nxt = smem_cs0_width_o;
        rw_by_cs_nxt = smem_cs0_rw_by_cs_o;
        // Retiming select 0 is software's job before the clock switch
        if (smem_cfg_load_i) begin
            byte_sel_nxt = smem_cfg_byte_sel_i;
            width_nxt = smem_cfg_width_i;
            rw_by_cs_nxt = smem_cfg_rw_by_cs_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_cs_to_sdram_o <= 1'b0;
            ext_nand_logic_o <= 1'b0;
            ext_card_logic_o <= 1'b0;
            boot_rom_o <= 1'b0;
            slow_src_xtal_o <= 1'b0;
            slow_clk_boot_o <= SLOW_BOOT_RST;
            smem_cs0_byte_sel_o <= SMEM_BYTE_SEL_RST;
            smem_cs0_width_o <= SMEM_WIDTH_RST;
            smem_cs0_rw_by_cs_o <= SMEM_RW_BY_CS_RST;
        end else begin
            ext_cs_to_sdram_o <= cs_sdram_nxt;
            ext_nand_logic_o <= nand_nxt;
            ext_card_logic_o <= card_nxt;
            boot_rom_o <= boot_rom_w;
            slow_src_xtal_o <= slow_xtal_w;
            slow_clk_boot_o <= slow_boot_nxt;
            smem_cs0_byte_sel_o <= byte_sel_nxt;
            smem_cs0_width_o <= width_nxt;
            smem_cs0_rw_by_cs_o <= rw_by_cs_nxt;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_boot_req;
        req_valid_i && req_ready_o && req_addr_i <= BOOT_AREA_LAST && !remap_i;
    endsequence

    property p_rom_boot;
        s_boot_req and (boot_rom_w == 1'b1) |=> resp_valid_o && resp_tgt_o == TGT_ROM;
    endproperty
    a_rom_boot: assert property (p_rom_boot) else $error("boot area not on ROM");

    property p_ext_boot;
        s_boot_req and (boot_rom_w == 1'b0) |=> resp_tgt_o == TGT_EXT && ext_chip_select_n_o == 8'hfe;
    endproperty
    a_ext_boot: assert property (p_ext_boot) else $error("boot area not on select 0");

    property p_remap;
        req_valid_i && req_ready_o && req_addr_i <= BOOT_AREA_LAST && remap_i |=> resp_tgt_o == TGT_SRAM0;
    endproperty
    a_remap: assert property (p_remap) else $error("remap ignored");

    property p_ext_bank;
        req_valid_i && req_ready_o && bank_of(req_addr_i) == 4'h3
            |=> ext_chip_select_n_o == 8'hfb && ext_addr_o == $past(req_addr_i[25:0]);
    endproperty
    a_ext_bank: assert property (p_ext_bank) else $error("bank 3 not on select 2");

    property p_abort;
        req_valid_i && req_ready_o && bank_of(req_addr_i) inside {[4'h8:4'he]}
            |=> resp_abort_o && ext_chip_select_n_o == 8'hff;
    endproperty
    a_abort: assert property (p_abort) else $error("unused area not aborted");

    property p_strap_hold;
        captured_w && $past(captured_w) |-> $stable(boot_rom_w);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("boot strap changed");

    // Ready rises one edge after capture; only a load on the first edge may move the setup
    property p_smem_default;
        $rose(captured_w) && !$past(smem_cfg_load_i)
            |-> smem_cs0_byte_sel_o == SMEM_BYTE_SEL_RST && smem_cs0_width_o == SMEM_WIDTH_RST
                && smem_cs0_rw_by_cs_o == SMEM_RW_BY_CS_RST;
    endproperty
    a_smem_default: assert property (p_smem_default) else $error("static memory setup not at boot default");

    property p_smem_hold;
        !$past(smem_cfg_load_i) && $past(smem_cs0_width_o) == SMEM_WIDTH_16 |-> smem_cs0_width_o == SMEM_WIDTH_16;
    endproperty
    a_smem_hold: assert property (p_smem_hold) else $error("static memory width drifted");

    property p_slow_boot;
        !slow_clk_boot_o |=> !slow_clk_boot_o;
    endproperty
    a_slow_boot: assert property (p_slow_boot) else $error("slow boot flag came back");

    property p_cs1_assign;
        cs1_sdram_i ##1 cs1_sdram_i |-> ext_cs_to_sdram_o;
    endproperty
    a_cs1_assign: assert property (p_cs1_assign) else $error("select 1 not handed to SDRAM");
endmodule : bmd_decoder

/* bmd_pkg.sv */
// Purpose: Shared constants and types for the boot memory select and address decoder
// Assumes: 32-bit system addresses, 16 banks of 256 Mbytes
// Notes: Reset values of the static memory boot setup live here
package bmd_pkg;
    localparam int ADDR_W = 32;
    localparam int EXT_ADDR_W = 26;
    localparam int EXT_DATA_W = 32;
    localparam int NUM_CS = 8;
    localparam int BANK_MSB = 31;
    localparam int BANK_LSB = 28;
    localparam logic [3:0] BANK_INT = 4'h0;
    localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
    localparam logic [3:0] BANK_EXT_LAST = 4'h7;
    localparam logic [3:0] BANK_PERIPH = 4'hf;
    localparam logic [31:0] BOOT_AREA_LAST = 32'h000f_ffff;
    localparam logic [3:0] CS_SDRAM_CAPABLE = 4'h1;
    localparam logic [3:0] CS_NAND_CAPABLE = 4'h3;
    localparam logic [3:0] CS_CARD_FIRST = 4'h4;
    localparam logic [3:0] CS_CARD_LAST = 4'h5;
    localparam logic BOOT_SEL_ROM = 1'b1;
    localparam logic SMEM_BYTE_SEL_RST = 1'b1;
    localparam logic [1:0] SMEM_WIDTH_8 = 2'h0;
    localparam logic [1:0] SMEM_WIDTH_16 = 2'h1;
    localparam logic [1:0] SMEM_WIDTH_32 = 2'h2;
    localparam logic [1:0] SMEM_WIDTH_RST = SMEM_WIDTH_16;
    localparam logic SMEM_RW_BY_CS_RST = 1'b1;
    localparam logic SLOW_BOOT_RST = 1'b1;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_ROM,
        TGT_SRAM0,
        TGT_INTMEM,
        TGT_EXT,
        TGT_PERIPH
    } bmd_tgt_e;
endpackage : bmd_pkg

/* bmd_strap_latch.sv */
// Purpose: Catch the boot-select and slow oscillator straps once after reset
// Assumes: Strap pins are steady around reset release
// Notes: Async reset loads constants only; the strap is taken on the first clock after release
`timescale 1ns/1ps
module bmd_strap_latch (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic boot_select_pin_i,
    input wire logic osc_xtal_sel_i,
    output logic boot_rom_o,
    output logic slow_src_xtal_o,
    output logic captured_o
);
    logic boot_rom_nxt;
    logic slow_src_xtal_nxt;
    logic captured_nxt;

    always_comb begin
        boot_rom_nxt = boot_rom_o;
        slow_src_xtal_nxt = slow_src_xtal_o;
        captured_nxt = 1'b1;
        // Only the first edge after release samples; later pin changes are ignored
        if (!captured_o) begin
            boot_rom_nxt = boot_select_pin_i;
            slow_src_xtal_nxt = osc_xtal_sel_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_rom_o <= 1'b0;
            slow_src_xtal_o <= 1'b0;
            captured_o <= 1'b0;
        end else begin
            boot_rom_o <= boot_rom_nxt;
            slow_src_xtal_o <= slow_src_xtal_nxt;
            captured_o <= captured_nxt;
        end
    end
endmodule : bmd_strap_latch

/* bmd_master_model.sv */
// Purpose: Bus master stand-in that issues single requests to the decoder
// Assumes: One request outstanding; it is held until taken
// Notes: Idle address and data flip every cycle so stale values never pass for live ones
`timescale 1ns/1ps
module bmd_master_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [31:0] addr_i,
    input wire logic req_ready_i,
    output logic req_valid_o,
    output logic [31:0] req_addr_o,
    output logic [31:0] req_wdata_o
);
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_valid_o <= 1'b0;
            req_addr_o <= 32'h0;
            req_wdata_o <= 32'h0;
        end else if (go_i) begin
            req_valid_o <= 1'b1;
            req_addr_o <= addr_i;
            req_wdata_o <= ~addr_i;
        end else if (req_valid_o && req_ready_i) begin
            req_valid_o <= 1'b0;
        end else if (!req_valid_o) begin
            req_addr_o <= ~req_addr_o;
            req_wdata_o <= ~req_wdata_o;
        end
    end
endmodule : bmd_master_model

/* boot_memory_select_decode_tb_top.sv */
// Purpose: Self-checking bench for the boot select and address decoder
// Assumes: Strap inputs change around reset, apart from one later strap change that must be ignored
// Notes: Expected values are worked out here from the bank layout
`timescale 1ns/1ps
module boot_memory_select_decode_tb_top;
    import bmd_pkg::*;
    logic ref_clk_i, rst_i, strap, xtal, remap, sdram, nand_en, card, sw_done, ld, bs, rw, go;
    logic rv, rdy, resp_v, abrt, boot_rom, slow, src_x, to_sd, nand_o, card_o, bs_o, rw_o;
    logic [1:0] wd, wd_o;
    logic [31:0] addr, ra, wdat, offs, ewd;
    logic [7:0] cs_n;
    logic [25:0] ea;
    bmd_tgt_e tgt;
    int num_errors = 0, n_checks = 0, cyc = 0;

    bmd_master_model mst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go), .addr_i(addr),
        .req_ready_i(rdy), .req_valid_o(rv), .req_addr_o(ra), .req_wdata_o(wdat));
    bmd_decoder uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .boot_select_pin_i(strap),
        .osc_xtal_sel_i(xtal), .remap_i(remap), .cs1_sdram_i(sdram), .cs3_nand_i(nand_en),
        .cs45_card_i(card), .clk_switch_done_i(sw_done), .smem_cfg_load_i(ld), .smem_cfg_byte_sel_i(bs),
        .smem_cfg_width_i(wd), .smem_cfg_rw_by_cs_i(rw), .req_valid_i(rv), .req_addr_i(ra),
        .req_wdata_i(wdat), .req_ready_o(rdy), .resp_valid_o(resp_v), .resp_abort_o(abrt),
        .resp_tgt_o(tgt), .resp_offset_o(offs), .ext_chip_select_n_o(cs_n), .ext_addr_o(ea),
        .ext_wdata_o(ewd), .ext_cs_to_sdram_o(to_sd), .ext_nand_logic_o(nand_o),
        .ext_card_logic_o(card_o), .boot_rom_o(boot_rom), .slow_clk_boot_o(slow),
        .slow_src_xtal_o(src_x), .smem_cs0_byte_sel_o(bs_o), .smem_cs0_width_o(wd_o),
        .smem_cs0_rw_by_cs_o(rw_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset(input logic s, input logic x);
        rst_i <= 1'b1;
        strap <= s;
        xtal <= x;
        repeat (2) @(posedge ref_clk_i);
        chk(32'(rdy), 32'h0);
        chk(32'(cs_n), 32'hff);
        chk(32'({bs_o, wd_o, rw_o}), 32'({SMEM_BYTE_SEL_RST, SMEM_WIDTH_16, SMEM_RW_BY_CS_RST}));
        chk(32'(slow), 32'h1);
        rst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk(32'(rdy), 32'h1);
    endtask : do_reset

    task automatic access(input logic [31:0] a, input bmd_tgt_e t, input logic [7:0] csn);
        int n;
        n = 0;
        go <= 1'b1;
        addr <= a;
        @(posedge ref_clk_i);
        go <= 1'b0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (resp_v !== 1'b1 && n < 8);
        chk(32'(resp_v), 32'h1);
        chk(32'(tgt), 32'(t));
        chk(32'(abrt), 32'(t == TGT_NONE));
        chk(32'(cs_n), 32'(csn));
        if (t != TGT_NONE) chk(offs, {4'h0, a[27:0]});
        if (t == TGT_EXT) chk({ewd[5:0], ea}, {~a[5:0], a[25:0]});
        @(posedge ref_clk_i);
        chk(32'(cs_n), 32'hff);
    endtask : access

    task automatic t_rom_boot();
        do_reset(1'b1, 1'b0);
        chk(32'(boot_rom), 32'h1);
        chk(32'(src_x), 32'h0);
        access(32'h0000_0010, TGT_ROM, 8'hff);
        access(32'h000f_fffc, TGT_ROM, 8'hff);
        access(32'h0010_0000, TGT_INTMEM, 8'hff);
        strap <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk(32'(boot_rom), 32'h1);
        access(32'h0000_0000, TGT_ROM, 8'hff);
    endtask : t_rom_boot

    task automatic t_ext_boot();
        do_reset(1'b0, 1'b1);
        chk(32'(boot_rom), 32'h0);
        chk(32'(src_x), 32'h1);
        access(32'h0000_0100, TGT_EXT, 8'hfe);
        access(32'h000f_ffff, TGT_EXT, 8'hfe);
        remap <= 1'b1;
        @(posedge ref_clk_i);
        access(32'h0000_0040, TGT_SRAM0, 8'hff);
        remap <= 1'b0;
    endtask : t_ext_boot

    task automatic t_banks();
        bmd_tgt_e t;
        logic [7:0] csn;
        for (int b = 1; b < 16; b++) begin
            t = (b <= 7) ? TGT_EXT : (b == 15) ? TGT_PERIPH : TGT_NONE;
            csn = (b <= 7) ? ~(8'h01 << (b - 1)) : 8'hff;
            access({4'(b), 28'h3ff_fabc}, t, csn);
        end
    endtask : t_banks

    task automatic t_config();
        chk(32'({to_sd, nand_o, card_o}), 32'h0);
        sdram <= 1'b1;
        nand_en <= 1'b1;
        card <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(32'({to_sd, nand_o, card_o}), 32'h7);
        bs <= 1'b0;
        wd <= SMEM_WIDTH_32;
        rw <= 1'b0;
        ld <= 1'b1;
        @(posedge ref_clk_i);
        ld <= 1'b0;
        sw_done <= 1'b1;
        @(posedge ref_clk_i);
        sw_done <= 1'b0;
        @(posedge ref_clk_i);
        chk(32'({bs_o, wd_o, rw_o}), 32'({1'b0, SMEM_WIDTH_32, 1'b0}));
        chk(32'(slow), 32'h0);
        repeat (4) @(posedge ref_clk_i);
        chk(32'(slow), 32'h0);
        access(32'h4000_0000, TGT_EXT, 8'hf7);
    endtask : t_config

    task automatic test_done();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    initial begin
        {rst_i, strap, xtal, remap, sdram, nand_en, card, sw_done, ld, bs, rw, go} = 12'h800;
        wd = 2'h0;
        addr = 32'h0;
        t_rom_boot();
        t_ext_boot();
        t_banks();
        t_config();
        test_done();
    end
endmodule : boot_memory_select_decode_tb_top
